// File: design/fdc_host_pkg.sv
// Constants and types shared by the floppy host phase handshake
package fdc_host_pkg;

  typedef enum logic [1:0] {
    mode_base    = 2'b00,
    mode_special = 2'b01,
    mode_pc      = 2'b10
  } mode_type;

  // Gray order along command -> execute -> result; result -> command flips both bits
  typedef enum logic [1:0] {
    phase_command = 2'b00,
    phase_execute = 2'b01,
    phase_result  = 2'b11
  } phase_type;

  localparam int CLOCK_PERIOD_NS = 10;
  localparam int BUFFER_DEPTH = 2;
  localparam int SYNC_WIDTH = 19;

  // Bit cell periods; 500/250/125 kb/s from the 16 MHz reference,
  // 300 kb/s from the 9.6 MHz reference
  localparam int REF_FAST_KHZ = 16000;
  localparam int REF_ALT_KHZ = 9600;
  localparam int DIV_500 = REF_FAST_KHZ / 500 / 32;
  localparam int DIV_250 = REF_FAST_KHZ / 250 / 32;
  localparam int DIV_125 = REF_FAST_KHZ / 125 / 32;
  localparam int DIV_300 = REF_ALT_KHZ / 300 / 32;
  localparam int CELL_NS_500 = 2000;
  localparam int CELL_CYCLES_500 = CELL_NS_500 / CLOCK_PERIOD_NS;
  localparam logic [15:0] RATE_CYCLES_500 = 16'(CELL_CYCLES_500 / DIV_500);
  localparam logic [15:0] RATE_CYCLES_250 =
    16'(CELL_CYCLES_500 * DIV_250 / DIV_500);
  localparam logic [15:0] RATE_CYCLES_125 =
    16'(CELL_CYCLES_500 * DIV_125 / DIV_500);
  localparam logic [15:0] RATE_CYCLES_300 = 16'(
    (CELL_CYCLES_500 * REF_FAST_KHZ * DIV_300) / (REF_ALT_KHZ * DIV_500));

  localparam logic [7:0] REDUCED_CURRENT_TRACK = 8'd28;

  // Main status bit positions
  localparam int MS_REQUEST = 7;
  localparam int MS_DIRECTION = 6;
  localparam int MS_EXECUTION = 5;
  localparam int MS_BUSY = 4;

  // Values after reset
  localparam logic [7:0] DATA_OUT_RESET = 8'h00;
  // Strobes, selects and drive pins idle high; terminal count idles low
  localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 19'h7df00;

endpackage

// File: design/two_entry_buffer.sv
// Small valid/ready FIFO that decouples the host side from the core
`timescale 1ns/1ns
module two_entry_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] head;
  logic [PW-1:0] tail;
  logic [PW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [PW-1:0] next_head = (head == PW'(DEPTH - 1)) ? '0 : head + 1'b1;
  wire [PW-1:0] next_tail = (tail == PW'(DEPTH - 1)) ? '0 : tail + 1'b1;

  assign in_ready = (count != (PW + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = store[head];

  always_ff @(posedge clock) begin
    if (push) begin
      store[tail] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      head <= '0;
      tail <= '0;
      count <= '0;
    end else begin
      if (push) begin
        tail <= next_tail;
      end
      if (pop) begin
        head <= next_head;
      end
      count <= count + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end
endmodule // two_entry_buffer

// File: design/floppy_host_phase_handshake.sv
// Host side phase handshake, status and drive pins of the floppy controller
`timescale 1ns/1ns
// Function
// - Head load output is driven low to load the selected drive's head.
// - Base or special mode: reduced current low when track exceeds 28.
// - PC mode: that pin is driven low when the low rate select bit is set, high when clear.
// - Low disk change input means door opened or diskette changed.
// - Low protect, track zero, index inputs read as their conditions.
// - 500/250/125 kb/s from 16 MHz reference, 300 kb/s from 9.6 MHz.
// - Special or PC mode: interrupt and DMA request float unless enabled.
// - Command byte taken only while status shows ready and host-to-device.
// - Result byte offered with both ready and direction bits set.
// - Non-DMA execute: interrupt per byte; read or write strobe clears it. Execution writes set it only when the full buffer frees a slot.
// - Host services each byte in time or polls the ready bit.
// - DMA mode: no data interrupts, request per byte, drop on acknowledge.
// - Execution end raises interrupt; first result read clears it.
// - PC mode: terminal count only counts with acknowledge active.
// - Chip select gates programmed strobes only; ignored during DMA.
// - New command refused until every result byte has been read.
// - Secondary status bytes readable only in the result phase.
// - Last command byte starts execution; last result byte ends command.
// - Main status readable any time without side effects.
// - Direction bit is 1 toward the processor, 0 from it.
// - Busy bit held while a command is in progress.
// - Execution bit set only in non-DMA execution, cleared in results.
module floppy_host_phase_handshake
  import fdc_host_pkg::*;
#(
  parameter int DEPTH = BUFFER_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Host bus pins
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic register_select,
  input wire logic dma_ack_n,
  input wire logic terminal_count,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  output logic irq,
  output logic irq_oe,
  output logic dma_req,
  output logic dma_req_oe,
  // Configuration
  input wire mode_type operating_mode,
  input wire logic dma_enable,
  input wire logic dma_mode,
  input wire logic rate_select_bit0,
  input wire logic rate_select_bit1,
  input wire logic drive_type_sel,
  input wire logic [3:0] drive_busy,
  // Drive pins and their decoded flags
  input wire logic head_load,
  input wire logic [7:0] current_track,
  output logic head_load_n,
  output logic reduced_write_current_n,
  input wire logic disk_change_n,
  input wire logic write_protect_n,
  input wire logic track_zero_n,
  input wire logic index_pulse_n,
  output logic disk_changed,
  output logic write_protected,
  output logic on_track_zero,
  output logic on_index,
  output logic rate_tick,
  // Bytes from host to core
  output logic [7:0] cmd_data,
  output logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic command_last,
  input wire logic exec_writes,
  // Bytes from core to host
  input wire logic [7:0] to_host_data,
  input wire logic to_host_valid,
  output logic to_host_ready,
  input wire logic to_host_last,
  // Phase control
  input wire logic exec_done,
  output logic terminal_count_hit,
  output phase_type phase
);

  logic [SYNC_WIDTH-1:0] sync_meta;
  logic [SYNC_WIDTH-1:0] sync_pins;
  logic read_prev;
  logic write_prev;
  logic tc_prev;
  logic [7:0] write_latch;
  logic [7:0] held_data;
  logic held_valid;
  logic held_last;
  logic command_begun;
  logic irq_flag;
  logic data_avail_prev;
  logic target_prev;
  logic [15:0] rate_count;

  // Pin inputs after two flops
  wire cs_s = ~sync_pins[18];
  wire rd_s = ~sync_pins[17];
  wire wr_s = ~sync_pins[16];
  wire sel_data_s = sync_pins[15];
  wire dack_s = ~sync_pins[14];
  wire tc_s = sync_pins[13];
  wire drv_s = sync_pins[12];
  wire [7:0] bus_s = sync_pins[7:0];

  // DMA cycles ignore chip select and the register select
  wire data_target = dack_s || (cs_s && sel_data_s);
  wire status_target = !dack_s && cs_s && !sel_data_s;
  wire read_lead = rd_s && !read_prev;
  wire read_trail = !rd_s && read_prev;
  wire write_lead = wr_s && !write_prev;
  wire write_trail = !wr_s && write_prev;
  wire data_strobe = (rd_s || wr_s) && data_target;

  // Buffer toward the core
  logic buf_in_ready;
  wire in_exec = (phase == phase_execute);
  wire in_result = (phase == phase_result);
  wire to_device = (phase == phase_command) || (in_exec && exec_writes);
  wire direction = !to_device;
  wire data_ready = to_device ? buf_in_ready : held_valid;
  wire request_ready = data_ready && !data_strobe;
  wire non_dma_exec = in_exec && !dma_mode;

  wire [7:0] main_status = {request_ready, direction, non_dma_exec,
    command_begun || (phase != phase_command), drive_busy};

  // Accepted transfers; the direction plus buffer space or a held byte admit them
  // Target from the cycle before the trailing edge, since chip select
  // and acknowledge may be released together with the strobe
  wire host_push = write_trail && target_prev && to_device
    && buf_in_ready;
  wire host_pop = read_trail && target_prev && !to_device
    && held_valid;
  wire first_result_read = read_lead && data_target && in_result
    && held_valid;
  wire data_clear = (read_lead || write_lead) && data_target
    && non_dma_exec;
  wire last_result_read = host_pop && in_result && held_last;

  // Terminal count in PC mode needs an active acknowledge
  wire tc_qualified = tc_s && !tc_prev
    && ((operating_mode != mode_pc) || dack_s);
  wire data_event = non_dma_exec && data_ready && !data_avail_prev;
  wire result_entry = in_exec && exec_done;

  wire floats_gated = (operating_mode != mode_base) && !dma_enable;

  // Bit cell period from the selected rate
  wire [15:0] rate_period =
    (!rate_select_bit1 && !rate_select_bit0) ? RATE_CYCLES_500 :
    (!rate_select_bit1 && drv_s) ? RATE_CYCLES_300 :
    (!rate_select_bit1) ? RATE_CYCLES_250 :
    (!rate_select_bit0) ? RATE_CYCLES_250 : RATE_CYCLES_125;
  wire rate_wrap = (rate_count >= rate_period - 16'h0001);

  logic [7:0] next_data_out;
  phase_type next_phase;

  assign next_data_out = status_target ? main_status
    : held_data;
  assign host_data_oe = rd_s && (status_target || data_target);
  assign irq_oe = !floats_gated;
  assign dma_req_oe = !floats_gated;
  assign irq = irq_flag;
  assign dma_req = dma_mode && in_exec && data_ready
    && !dack_s;
  assign to_host_ready = !held_valid && (phase != phase_command);
  assign head_load_n = ~head_load;
  assign disk_changed = ~sync_pins[11];
  assign write_protected = ~sync_pins[10];
  assign on_track_zero = ~sync_pins[9];
  assign on_index = ~sync_pins[8];

  always_comb begin
    next_phase = phase;
    unique case (phase)
      phase_command: begin
        if (command_last) begin
          next_phase = phase_execute;
        end
      end
      phase_execute: begin
        if (exec_done) begin
          next_phase = phase_result;
        end
      end
      phase_result: begin
        if (last_result_read) begin
          next_phase = phase_command;
        end
      end
      default: next_phase = phase_command;
    endcase
  end

  two_entry_buffer #(.WIDTH(8), .DEPTH(DEPTH)) to_core (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(host_push),
    .in_data(write_latch),
    .in_ready(buf_in_ready),
    .out_valid(cmd_valid),
    .out_data(cmd_data),
    .out_ready(cmd_ready)
  );

  // Pin synchroniser; first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_meta <= SYNC_RESET;
      sync_pins <= SYNC_RESET;
    end else begin
      sync_meta <= {chip_select_n, read_n, write_n, register_select,
        dma_ack_n, terminal_count, drive_type_sel, disk_change_n,
        write_protect_n, track_zero_n, index_pulse_n, host_data_in};
      sync_pins <= sync_meta;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      read_prev <= 1'b0;
      write_prev <= 1'b0;
      tc_prev <= 1'b0;
      data_avail_prev <= 1'b0;
      target_prev <= 1'b0;
      write_latch <= DATA_OUT_RESET;
      host_data_out <= DATA_OUT_RESET;
    end else begin
      read_prev <= rd_s;
      write_prev <= wr_s;
      tc_prev <= tc_s;
      data_avail_prev <= data_ready;
      target_prev <= data_target;
      // Latched while the strobe is low so zero hold time is safe
      if (wr_s) begin
        write_latch <= bus_s;
      end
      host_data_out <= next_data_out;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase <= phase_command;
      command_begun <= 1'b0;
      terminal_count_hit <= 1'b0;
    end else begin
      phase <= next_phase;
      terminal_count_hit <= in_exec && tc_qualified;
      if (host_push && phase == phase_command) begin
        command_begun <= 1'b1;
      end else if (phase != phase_command) begin
        command_begun <= 1'b0;
      end
    end
  end

  // Byte held for the host, shared by execution reads and results
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      held_valid <= 1'b0;
      held_last <= 1'b0;
      held_data <= DATA_OUT_RESET;
    end else if (to_host_valid && to_host_ready) begin
      held_valid <= 1'b1;
      held_last <= to_host_last && in_result;
      held_data <= to_host_data;
    end else if (host_pop) begin
      held_valid <= 1'b0;
    end
  end

  // Interrupt: set beats clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_flag <= 1'b0;
    end else if (data_event || result_entry) begin
      irq_flag <= 1'b1;
    end else if (data_clear || first_result_read) begin
      irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reduced_write_current_n <= 1'b1;
    end else if (operating_mode == mode_pc) begin
      reduced_write_current_n <= ~rate_select_bit0;
    end else begin
      reduced_write_current_n <=
        ~(current_track > REDUCED_CURRENT_TRACK);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rate_count <= 16'h0000;
      rate_tick <= 1'b0;
    end else begin
      rate_count <= rate_wrap ? 16'h0000 : rate_count + 16'h0001;
      rate_tick <= rate_wrap;
    end
  end

endmodule // floppy_host_phase_handshake

// File: sim/host_phase_props.sv
// Port assertions for the floppy host phase handshake
`timescale 1ns/1ns
module host_phase_props
  import fdc_host_pkg::*;
#(
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Inputs of interest
  input wire mode_type operating_mode,
  input wire logic dma_enable,
  input wire logic dma_mode,
  input wire logic rate_select_bit0,
  input wire logic head_load,
  input wire logic [7:0] current_track,
  input wire logic disk_change_n,
  input wire logic dma_ack_n,
  input wire logic command_last,
  input wire logic exec_done,
  // Outputs watched
  input wire logic head_load_n,
  input wire logic reduced_write_current_n,
  input wire logic disk_changed,
  input wire logic irq,
  input wire logic irq_oe,
  input wire logic dma_req,
  input wire phase_type phase
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_head;
    head_load_n == !head_load;
  endproperty
  a_head: assert property (p_head) else $error("head load level");
  property p_rwc;
    1 |=> reduced_write_current_n == (($past(operating_mode) == mode_pc) ?
      !$past(rate_select_bit0) :
      !($past(current_track) > REDUCED_CURRENT_TRACK));
  endproperty
  a_rwc: assert property (p_rwc) else $error("write current");
  property p_oe;
    irq_oe == !(operating_mode != mode_base && !dma_enable);
  endproperty
  a_oe: assert property (p_oe) else $error("request float");
  property p_flag;
    disk_changed == !$past(disk_change_n, 2);
  endproperty
  a_flag: assert property (p_flag) else $error("disk change");
  property p_ack;
    !dma_ack_n [*3] |-> !dma_req;
  endproperty
  a_ack: assert property (p_ack) else $error("request kept");
  property p_dreq;
    dma_req |-> phase == phase_execute && dma_mode;
  endproperty
  a_dreq: assert property (p_dreq) else $error("stray request");
  property p_irq_dma;
    $rose(irq) |-> !(dma_mode && phase == phase_execute);
  endproperty
  a_irq_dma: assert property (p_irq_dma) else $error("dma irq");
  property p_done;
    exec_done && phase == phase_execute |=> phase == phase_result && irq;
  endproperty
  a_done: assert property (p_done) else $error("no result");
  property p_last;
    command_last && phase == phase_command |=> phase == phase_execute;
  endproperty
  a_last: assert property (p_last) else $error("no execute");

  c_dma: cover property (dma_req);
  c_irq: cover property ($fell(irq) && phase == phase_result);
  c_end: cover property (phase == phase_result ##1 phase == phase_command);
endmodule // host_phase_props

// File: sim/host_bus_model.sv
// Host processor and DMA controller on the peripheral bus
`timescale 1ns/1ns
module host_bus_model (
  // Clock
  input wire logic clock,
  // Bus toward the controller
  output logic chip_select_n,
  output logic read_n,
  output logic write_n,
  output logic register_select,
  output logic dma_ack_n,
  output logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out
);
  initial begin
    chip_select_n = 1'b1;
    read_n = 1'b1;
    write_n = 1'b1;
    register_select = 1'b0;
    dma_ack_n = 1'b1;
    host_data_in = 8'h00;
  end

  // Strobes and gaps span six cycles, beyond the synchroniser needs
  task automatic cyc(input logic sel, wr, dma, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clock);
    register_select = sel;
    chip_select_n = dma;
    dma_ack_n = !dma;
    host_data_in = d;
    if (wr)
      write_n = 1'b0;
    else
      read_n = 1'b0;
    repeat (6) @(posedge clock);
    q = host_data_out;
    @(negedge clock);
    read_n = 1'b1;
    write_n = 1'b1;
    chip_select_n = 1'b1;
    dma_ack_n = 1'b1;
    host_data_in = ~d;
    repeat (6) @(negedge clock);
  endtask

  // Status is read until its top two bits match, eight reads at most
  task automatic poll(input logic [1:0] want, output logic [7:0] q);
    q = 8'h00;
    for (int i = 0; i < 8 && q[7:6] !== want; i++)
      cyc(1'b0, 1'b0, 1'b0, 8'h00, q);
  endtask
endmodule // host_bus_model

// File: sim/floppy_host_phase_handshake_tb_top.sv
// Self-checking bench for the floppy host phase handshake
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  err_count++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module floppy_host_phase_handshake_tb_top;
  import fdc_host_pkg::*;
  logic clock, rst_n, chip_select_n, read_n, write_n, register_select;
  logic dma_ack_n, dma_enable, dma_mode, rate_select_bit0, head_load;
  logic host_data_oe, irq, irq_oe, dma_req, dma_req_oe, head_load_n;
  logic reduced_write_current_n, disk_changed, write_protected;
  logic on_track_zero, on_index, rate_tick, cmd_valid, cmd_ready;
  logic to_host_valid, to_host_ready, to_host_last, terminal_count_hit;
  logic [7:0] host_data_in, host_data_out, current_track, cmd_data;
  logic [7:0] to_host_data, st;
  logic [3:0] pins, drive_busy;
  logic [1:0] ev;
  logic tc;
  mode_type operating_mode;
  phase_type phase;
  int err_count, comparisons, cycles;
  wire [3:0] flags = {disk_changed, write_protected, on_track_zero, on_index};

  host_bus_model host (.clock(clock), .chip_select_n(chip_select_n),
    .read_n(read_n), .write_n(write_n), .register_select(register_select),
    .dma_ack_n(dma_ack_n), .host_data_in(host_data_in),
    .host_data_out(host_data_out));

  // Unused core features are tied off to keep the bench small
  floppy_host_phase_handshake #(.DEPTH(2)) DUT (.clock(clock),
    .rst_n(rst_n), .chip_select_n(chip_select_n), .read_n(read_n),
    .write_n(write_n), .register_select(register_select),
    .dma_ack_n(dma_ack_n), .terminal_count(tc),
    .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .irq(irq), .irq_oe(irq_oe),
    .dma_req(dma_req), .dma_req_oe(dma_req_oe),
    .operating_mode(operating_mode), .dma_enable(dma_enable),
    .dma_mode(dma_mode), .rate_select_bit0(rate_select_bit0),
    .rate_select_bit1(1'b0), .drive_type_sel(1'b0),
    .drive_busy(drive_busy), .head_load(head_load),
    .current_track(current_track), .head_load_n(head_load_n),
    .reduced_write_current_n(reduced_write_current_n),
    .disk_change_n(pins[3]), .write_protect_n(pins[2]),
    .track_zero_n(pins[1]), .index_pulse_n(pins[0]),
    .disk_changed(disk_changed), .write_protected(write_protected),
    .on_track_zero(on_track_zero), .on_index(on_index),
    .rate_tick(rate_tick), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .command_last(ev[0]), .exec_writes(1'b0),
    .to_host_data(to_host_data), .to_host_valid(to_host_valid),
    .to_host_ready(to_host_ready), .to_host_last(to_host_last),
    .exec_done(ev[1]), .terminal_count_hit(terminal_count_hit),
    .phase(phase));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic pulse(input logic [1:0] v);
    @(negedge clock);
    ev = v;
    @(negedge clock);
    ev = 2'b00;
    repeat (2) @(negedge clock);
  endtask

  task automatic offer(input logic [7:0] d, input logic last);
    @(negedge clock);
    to_host_data = d;
    to_host_last = last;
    to_host_valid = 1'b1;
    for (int i = 0; i < 50 && !to_host_ready; i++)
      @(posedge clock);
    @(negedge clock);
    to_host_valid = 1'b0;
    to_host_data = ~d;
    repeat (4) @(negedge clock);
  endtask

  task automatic take(input logic [7:0] exp);
    @(negedge clock);
    cmd_ready = 1'b1;
    for (int i = 0; i < 50 && !cmd_valid; i++)
      @(posedge clock);
    `CHK(cmd_data, exp)
    @(negedge clock);
    cmd_ready = 1'b0;
  endtask

  task automatic send(input logic [7:0] d);
    host.poll(2'b10, st);
    `CHK(st[7:6], 2'b10)
    host.cyc(1'b1, 1'b1, 1'b0, d, st);
  endtask

  task automatic t_pins();
    head_load = 1'b1;
    current_track = 8'd28;
    pins = 4'h0;
    repeat (4) @(negedge clock);
    `CHK({head_load_n, reduced_write_current_n}, 2'b01)
    `CHK(flags, 4'hf)
    current_track = 8'd29;
    operating_mode = mode_special;
    repeat (2) @(negedge clock);
    `CHK({reduced_write_current_n, irq_oe}, 2'b00)
    operating_mode = mode_pc;
    dma_enable = 1'b1;
    repeat (2) @(negedge clock);
    `CHK({reduced_write_current_n, dma_req_oe}, 2'b11)
    rate_select_bit0 = 1'b1;
    repeat (2) @(negedge clock);
    `CHK(reduced_write_current_n, 1'b0)
    operating_mode = mode_base;
    pins = 4'hf;
  endtask

  task automatic t_idle();
    host.cyc(1'b0, 1'b0, 1'b0, 8'h00, st);
    `CHK({st, irq, dma_req, phase, host_data_oe}, {8'h85, 5'h00})
  endtask

  // Third byte hits a full buffer while the core stalls
  task automatic t_cmd();
    send(8'h46);
    send(8'h21);
    host.cyc(1'b1, 1'b1, 1'b0, 8'h99, st);
    host.cyc(1'b0, 1'b0, 1'b0, 8'h00, st);
    `CHK(st[4], 1'b1)
    take(8'h46);
    take(8'h21);
    repeat (4) @(negedge clock);
    `CHK({cmd_valid, to_host_ready}, 2'b00)
    pulse(2'b01);
    `CHK(phase, phase_execute)
  endtask

  task automatic t_exec();
    offer(8'h3c, 1'b0);
    `CHK(irq, 1'b1)
    host.cyc(1'b0, 1'b0, 1'b0, 8'h00, st);
    `CHK({st, irq}, {8'hf5, 1'b1})
    host.cyc(1'b1, 1'b0, 1'b0, 8'h00, st);
    `CHK({st, irq}, {8'h3c, 1'b0})
    host.cyc(1'b0, 1'b0, 1'b0, 8'h00, st);
    `CHK(st[7], 1'b0)
  endtask

  task automatic t_result();
    pulse(2'b10);
    `CHK({phase, irq}, {phase_result, 1'b1})
    offer(8'ha1, 1'b0);
    host.poll(2'b11, st);
    `CHK(st[7:5], 3'b110)
    host.cyc(1'b1, 1'b0, 1'b0, 8'h00, st);
    `CHK({st, irq}, {8'ha1, 1'b0})
    host.cyc(1'b1, 1'b1, 1'b0, 8'h77, st);
    repeat (4) @(negedge clock);
    `CHK(cmd_valid, 1'b0)
    offer(8'ha2, 1'b1);
    host.cyc(1'b1, 1'b0, 1'b0, 8'h00, st);
    `CHK({st, phase}, {8'ha2, phase_command})
    host.cyc(1'b0, 1'b0, 1'b0, 8'h00, st);
    `CHK(st, 8'h85)
  endtask

  // Terminal count edge during execution; the hit pulse stands one cycle
  task automatic t_tc(input mode_type m, input logic exp);
    operating_mode = m;
    tc = 1'b1;
    repeat (3) @(negedge clock);
    `CHK(terminal_count_hit, exp)
    @(negedge clock);
    `CHK(terminal_count_hit, 1'b0)
    tc = 1'b0;
    operating_mode = mode_base;
    repeat (3) @(negedge clock);
  endtask

  task automatic t_rate();
    int n;
    n = 0;
    while (!rate_tick)
      @(negedge clock);
    do begin
      @(negedge clock);
      n++;
    end while (!rate_tick);
    `CHK(16'(n), RATE_CYCLES_250)
  endtask

  task automatic t_dma();
    dma_mode = 1'b1;
    send(8'h06);
    take(8'h06);
    pulse(2'b01);
    offer(8'h5a, 1'b0);
    `CHK({dma_req, irq}, 2'b10)
    host.cyc(1'b1, 1'b0, 1'b1, 8'h00, st);
    `CHK({st, dma_req}, {8'h5a, 1'b0})
    t_tc(mode_base, 1'b1);
    t_tc(mode_pc, 1'b0);
    pulse(2'b10);
    offer(8'hee, 1'b1);
    host.cyc(1'b1, 1'b0, 1'b0, 8'h00, st);
    `CHK({st, phase}, {8'hee, phase_command})
    dma_mode = 1'b0;
  endtask

  initial begin
    rst_n = 1'b0;
    {dma_enable, dma_mode, rate_select_bit0, head_load} = 4'h0;
    {cmd_ready, to_host_valid, to_host_last, ev, tc} = 6'h00;
    {to_host_data, current_track} = 16'h0000;
    pins = 4'hf;
    drive_busy = 4'h5;
    operating_mode = mode_base;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    t_pins();
    t_idle();
    t_cmd();
    t_exec();
    t_result();
    t_dma();
    t_rate();
    wrap_up();
  end
endmodule // floppy_host_phase_handshake_tb_top

bind floppy_host_phase_handshake host_phase_props #(.DEPTH(DEPTH)) u_props (
  .clock(clock), .rst_n(rst_n), .operating_mode(operating_mode),
  .dma_enable(dma_enable), .dma_mode(dma_mode),
  .rate_select_bit0(rate_select_bit0), .head_load(head_load),
  .current_track(current_track), .disk_change_n(disk_change_n),
  .dma_ack_n(dma_ack_n), .command_last(command_last),
  .exec_done(exec_done), .head_load_n(head_load_n),
  .reduced_write_current_n(reduced_write_current_n),
  .disk_changed(disk_changed), .irq(irq), .irq_oe(irq_oe),
  .dma_req(dma_req), .phase(phase));
